// ### adc_mux_bus_handshake_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_mux_bus_handshake_bench;
  logic               clk;
  logic               nrst;
  logic [7:0]         analog;
  wire                cs_n, ld_n, rd_n, oe, done_n, conv, comp_hi;
  wire [7:0]          hbus, bus_in, dout, trial;
  wire [4:0]          csel;
  amb_pkg::amb_mode_t mode;
  int                 fail_count, checks, cyc;
  // clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // comparator and bus resolution
  assign comp_hi = (trial <= analog);
  assign bus_in = oe ? dout : hbus;
  amb_host h (.clk(clk), .cs_n(cs_n), .ld_n(ld_n), .rd_n(rd_n), .bus(hbus));
  amb_ctrl #(.EIGHT_CH(1'b1)) u_dut (.clk(clk), .nrst(nrst), .dev_select_n(cs_n), .load_strobe_n(ld_n),
    .read_strobe_n(rd_n), .shared_bus_lines_in(bus_in), .comp_hi(comp_hi), .shared_bus_lines_out(dout),
    .shared_bus_lines_oe(oe), .conversion_done_n(done_n), .channel_select_bits(csel), .mux_mode(mode),
    .dac_trial(trial), .converting(conv));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp1(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done_n !== 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    cmp1(done_n, 1'b0);
  endtask
  task automatic t_reset();
    cmp1(done_n, 1'b1);
    cmp1(oe, 1'b0);
    cmp8({3'h0, csel}, 8'h00);
    cmp8({6'h0, mode}, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_convert(input logic [4:0] a, input logic [7:0] v, input logic [1:0] m);
    analog = v;
    h.ld_fall({3'h5, a}, 1'b0);
    h.ld_rise();
    cmp8({3'h0, csel}, {3'h0, a});
    cmp8({6'h0, mode}, {6'h0, m});
    cmp1(conv, 1'b1);
    cmp1(oe, 1'b0);
    wait_done();
    repeat (100) @(negedge clk);
    cmp1(done_n, 1'b0);
    h.rd_fall();
    cmp1(oe, 1'b1);
    cmp8(dout, v);
    cmp1(done_n, 1'b1);
    h.rd_rise();
    cmp1(oe, 1'b0);
    $display("convert test %h done", a);
  endtask
  task automatic t_keep();
    analog = 8'h3c;
    h.ld_fall(8'h18, 1'b0);
    h.ld_rise();
    wait_done();
    repeat (25) @(negedge clk);
    h.ld_fall(8'h01, 1'b1);
    cmp1(done_n, 1'b1);
    cmp1(oe, 1'b1);
    cmp8(dout, 8'h3c);
    h.ld_rise();
    cmp8({3'h0, csel}, 8'h18);
    cmp8({6'h0, mode}, 8'h02);
    cmp1(conv, 1'b0);
    $display("keep test done");
  endtask
  task automatic t_abort();
    analog = 8'ha5;
    h.ld_fall(8'h0b, 1'b0);
    h.ld_rise();
    repeat (300) @(negedge clk);
    cmp1(conv, 1'b1);
    analog = 8'h42;
    h.ld_fall(8'h00, 1'b0);
    cmp1(conv, 1'b0);
    cmp1(done_n, 1'b1);
    h.ld_rise();
    wait_done();
    h.rd_fall();
    cmp8(dout, 8'h42);
    h.rd_rise();
    $display("abort test done");
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end
  // main sequence
  initial
  begin
    nrst = 1'b0;
    analog = 8'h00;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_reset();
    t_convert(5'h00, 8'h5a, 2'h0);
    t_convert(5'h0b, 8'hff, 2'h1);
    t_convert(5'h1e, 8'h01, 2'h2);
    t_convert(5'h12, 8'h00, 2'h0);
    t_keep();
    t_abort();
    close_out();
  end
endmodule
`default_nettype wire

// ### amb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module amb_ctrl
#(
  parameter bit EIGHT_CH = 1'b1
)
(
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        dev_select_n,
  input  wire logic                        load_strobe_n,
  input  wire logic                        read_strobe_n,
  input  wire logic [amb_pkg::DATA_W-1:0]  shared_bus_lines_in,
  input  wire logic                        comp_hi,
  output logic [amb_pkg::DATA_W-1:0]       shared_bus_lines_out,
  output logic                             shared_bus_lines_oe,
  output logic                             conversion_done_n,
  output logic [amb_pkg::ADDR_W-1:0]       channel_select_bits,
  output amb_pkg::amb_mode_t               mux_mode,
  output logic [amb_pkg::DATA_W-1:0]       dac_trial,
  output logic                             converting
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0]                    pin_meta;
  logic [2:0]                    pin_sync;
  logic [amb_pkg::DATA_W-1:0]    bus_meta;
  logic [amb_pkg::DATA_W-1:0]    bus_sync;
  logic                          load_prev;

  // synced pin levels
  wire cs_n_s   = pin_sync[2];
  wire load_n_s = pin_sync[1];
  wire rd_n_s   = pin_sync[0];

  // two flops on every strobe and bus pin before use; comp_hi goes to the converter unsynced
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta  <= 3'h7;
      pin_sync  <= 3'h7;
      bus_meta  <= 8'h00;
      bus_sync  <= 8'h00;
      load_prev <= 1'b1;
    end
    else
    begin
      pin_meta  <= {dev_select_n, load_strobe_n, read_strobe_n};
      pin_sync  <= pin_meta;
      bus_meta  <= shared_bus_lines_in;
      bus_sync  <= bus_meta;
      load_prev <= load_n_s;
    end
  end

  // ---------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------
  // edges come from the synced levels, two cycles behind the pins
  wire load_active = !cs_n_s && !load_n_s;
  wire load_fall   = load_active && load_prev;
  wire load_rise   = !cs_n_s && load_n_s && !load_prev;
  wire read_active = !cs_n_s && !rd_n_s;
  logic rd_low_all;                                     // read held low for whole load pulse

  // read low at load fall arms keep, any read high during the pulse disarms it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_low_all <= 1'b0;
    end
    else if (load_fall)
    begin
      rd_low_all <= !rd_n_s;
    end
    else if (load_active && rd_n_s)
    begin
      rd_low_all <= 1'b0;
    end
  end

  // address accepted only with read high at the rising edge
  wire addr_take  = load_rise && rd_n_s && !rd_low_all;
  wire keep_cfg   = load_rise && rd_low_all;
  wire conv_start = addr_take;

  // ---------------------------------------------------------------
  // mode decode from the latched address
  // ---------------------------------------------------------------
  // the mode field sits one bit higher in the eight channel map
  wire [1:0] mode_bits = channel_select_bits[amb_pkg::MODE_MSB:amb_pkg::MODE_LSB];
  wire [1:0] mode8     = channel_select_bits[4:3];
  wire [1:0] mode_sel  = EIGHT_CH ? mode8 : mode_bits;
  amb_pkg::amb_mode_t next_mode;

  // low mode bit clear is differential whatever the high bit holds
  assign next_mode = (mode_sel[0] == 1'b0)               ? amb_pkg::AMB_MODE_DIFF :
                     (mode_sel == amb_pkg::MODE_SE_4CH) ? amb_pkg::AMB_MODE_SINGLE :
                                                          amb_pkg::AMB_MODE_PSEUDO;

  // ---------------------------------------------------------------
  // converter core
  // ---------------------------------------------------------------
  logic [amb_pkg::DATA_W-1:0] trial;
  logic                       sar_done;

  // load fall aborts a running conversion
  amb_sar u_sar
  (
    .clk     (clk),
    .nrst    (nrst),
    .start   (conv_start),
    .abort   (load_fall),
    .comp_hi (comp_hi),
    .trial   (trial),
    .done    (sar_done)
  );

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  amb_pkg::amb_state_t state;
  amb_pkg::amb_state_t next_state;
  logic [amb_pkg::DATA_W-1:0] result;

  // control sequencing: idle, converting, result waiting
  always_comb
  begin
    next_state = state;
    unique case (state)
      amb_pkg::AMB_ST_IDLE:
        if (conv_start) next_state = amb_pkg::AMB_ST_CONVERT;
      amb_pkg::AMB_ST_CONVERT:
        if (load_fall) next_state = amb_pkg::AMB_ST_IDLE;
        else if (sar_done) next_state = amb_pkg::AMB_ST_DONE;
      amb_pkg::AMB_ST_DONE:
        if (load_fall || read_active) next_state = amb_pkg::AMB_ST_IDLE;
        else if (conv_start) next_state = amb_pkg::AMB_ST_CONVERT;
    endcase
  end

  // state, result latch and address latch
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state               <= amb_pkg::AMB_ST_IDLE;
      result              <= amb_pkg::RESULT_RST;
      channel_select_bits <= amb_pkg::MUX_ADDR_RST;
    end
    else
    begin
      state <= next_state;
      // an aborted conversion never reaches the output latch
      if (sar_done && !load_fall)
      begin
        result <= trial;
      end
      if (addr_take)
      begin
        channel_select_bits <= bus_sync[amb_pkg::ADDR_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  // load fall outranks a finishing conversion
  wire done_set   = (state == amb_pkg::AMB_ST_CONVERT) && sar_done && !load_fall;
  wire done_clear = load_fall || read_active;
  wire drive_bus  = read_active;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      conversion_done_n    <= 1'b1;
      shared_bus_lines_out <= 8'h00;
      shared_bus_lines_oe  <= 1'b0;
      mux_mode             <= amb_pkg::AMB_MODE_DIFF;
      dac_trial            <= 8'h00;
      converting           <= 1'b0;
    end
    else
    begin
      // a finishing conversion beats a read in the same cycle
      if (done_set)
      begin
        conversion_done_n <= 1'b0;
      end
      else if (done_clear)
      begin
        conversion_done_n <= 1'b1;
      end
      // data follows the result latch; the enable alone gates the bus
      shared_bus_lines_out <= result;
      shared_bus_lines_oe  <= drive_bus;
      // a keep-config write leaves the mux mode alone
      if (!keep_cfg)
      begin
        mux_mode <= next_mode;
      end
      // trial code and busy level to the pins
      dac_trial  <= trial;
      converting <= (next_state == amb_pkg::AMB_ST_CONVERT);
    end
  end

endmodule
`default_nettype wire

// ### amb_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks on the converter handshake
module amb_ctrl_props
(
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic                        dev_select_n,
  input wire logic                        load_strobe_n,
  input wire logic                        read_strobe_n,
  input wire logic                        shared_bus_lines_oe,
  input wire logic                        conversion_done_n,
  input wire logic [amb_pkg::ADDR_W-1:0]  channel_select_bits,
  input wire logic                        converting
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // cycles spent converting, saturating; bound is the nominal time plus sync slack
  localparam logic [10:0] CONV_LIMIT = 11'(amb_pkg::CONV_CYCLES + 8);
  logic [10:0]            conv_len;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      conv_len <= 11'h000;
    end
    else if (!converting)
    begin
      conv_len <= 11'h000;
    end
    else if (conv_len != 11'h7ff)
    begin
      conv_len <= conv_len + 11'h001;
    end
  end
  // bus, flag, address and conversion-time relations
  AST_OE_OFF: assert property ((dev_select_n || read_strobe_n)[*5] |-> !shared_bus_lines_oe)
    else $error("bus driven outside a read");
  AST_DONE_CLR_RD: assert property ((!dev_select_n && !read_strobe_n)[*5] |-> conversion_done_n)
    else $error("done flag not cleared by read");
  AST_DONE_CLR_LD: assert property ((!dev_select_n && !load_strobe_n)[*5] |-> conversion_done_n)
    else $error("done flag not cleared by load");
  AST_DONE_HOLD: assert property ($rose(conversion_done_n) |-> !$past(dev_select_n, 3))
    else $error("done flag rose without select");
  AST_DONE_FALL: assert property ($fell(conversion_done_n) |-> $past(converting) || $past(converting, 2))
    else $error("done flag fell without conversion");
  AST_ADDR: assert property ($changed(channel_select_bits) |-> $past(read_strobe_n, 3))
    else $error("address taken with read low");
  AST_CONV_MIN: assert property ($rose(converting) |-> converting[*8])
    else $error("conversion ended early");
  AST_CONV_MAX: assert property (conv_len <= CONV_LIMIT)
    else $error("conversion too long");
endmodule
bind amb_ctrl amb_ctrl_props u_props (.clk(clk), .nrst(nrst), .dev_select_n(dev_select_n),
  .load_strobe_n(load_strobe_n), .read_strobe_n(read_strobe_n), .shared_bus_lines_oe(shared_bus_lines_oe),
  .conversion_done_n(conversion_done_n), .channel_select_bits(channel_select_bits), .converting(converting));
`default_nettype wire

// ### amb_host.sv
`timescale 1ns/1ps
`default_nettype none
// host processor driving the strobes
module amb_host
(
  input  wire logic  clk,
  output logic       cs_n,
  output logic       ld_n,
  output logic       rd_n,
  output logic [7:0] bus
);
  // idle pins
  initial
  begin
    cs_n = 1'b1;
    ld_n = 1'b1;
    rd_n = 1'b1;
    bus = 8'h00;
  end
  // select and load low together
  task automatic ld_fall(input logic [7:0] d, input logic rd_low);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = !rd_low;
    bus = d;
    ld_n = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // load rise, hold data, release
  task automatic ld_rise();
    ld_n = 1'b1;
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    rd_n = 1'b1;
    bus = ~bus; // released bus shows no stale value
  endtask
  // read only well after the flag falls
  task automatic rd_fall();
    repeat (25) @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  // end of read
  task automatic rd_rise();
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### amb_pkg.sv
`default_nettype none
package amb_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 5;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned CONV_TIME_NS   = 40000;  // longest conversion, 40 us
  // longest time rounds down
  localparam int unsigned CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;
  // successive approximation: one step per result bit
  localparam int unsigned STEP_CYCLES    = CONV_CYCLES / DATA_W;
  localparam int unsigned STEP_CNT_W     = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MUX_ADDR_RST = 5'h00;
  localparam logic [DATA_W-1:0] RESULT_RST   = 8'h00;

  // ---------------------------------------------------------------
  // multiplexer mode field, address bits 3 and 2
  // ---------------------------------------------------------------
  localparam int unsigned MODE_LSB = 2;
  localparam int unsigned MODE_MSB = 3;
  localparam logic [1:0] MODE_SE_4CH = 2'h1;  // single ended in 4-channel map

  typedef enum logic [1:0]
  {
    AMB_MODE_DIFF,
    AMB_MODE_SINGLE,
    AMB_MODE_PSEUDO
  } amb_mode_t;

  typedef enum logic [1:0]
  {
    AMB_ST_IDLE,
    AMB_ST_CONVERT,
    AMB_ST_DONE
  } amb_state_t;

endpackage
`default_nettype wire

// ### amb_sar.sv
`timescale 1ns/1ps
`default_nettype none
module amb_sar
(
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         start,
  input  wire logic                         abort,
  input  wire logic                         comp_hi,
  output logic [amb_pkg::DATA_W-1:0]        trial,
  output logic                              done
);

  // ---------------------------------------------------------------
  // successive approximation sequencer
  // ---------------------------------------------------------------
  logic [amb_pkg::STEP_CNT_W-1:0] step_cnt;
  logic [2:0]                     bit_idx;
  logic                           busy;
  wire                            step_end = (step_cnt == amb_pkg::STEP_CNT_W'(amb_pkg::STEP_CYCLES - 1));
  wire  [amb_pkg::DATA_W-1:0]     bit_mask = amb_pkg::DATA_W'(1) << bit_idx;
  wire  [amb_pkg::DATA_W-1:0]     kept     = comp_hi ? trial : (trial & ~bit_mask);
  wire  [amb_pkg::DATA_W-1:0]     next_trial = (bit_idx == 3'h0) ? kept : (kept | (bit_mask >> 1));

  // one trial bit per step, msb first
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy     <= 1'b0;
      step_cnt <= '0;
      bit_idx  <= 3'h7;
      trial    <= amb_pkg::RESULT_RST;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        busy <= 1'b0;
      end
      else if (start)
      begin
        busy     <= 1'b1;
        step_cnt <= '0;
        bit_idx  <= 3'h7;
        trial    <= 8'h80;
      end
      else if (busy)
      begin
        step_cnt <= step_end ? '0 : step_cnt + 1'b1;
        if (step_end)
        begin
          trial   <= next_trial;
          bit_idx <= bit_idx - 3'h1;
          if (bit_idx == 3'h0)
          begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire
